// file: design/opbc_pkg.sv
// Purpose : Shared constants and types for the OTP and page buffer command block
// Assumes : 50 MHz system clock, SPI inputs already synchronous to it
// Notes   : Times are in microseconds; cycle counts are derived from them
package opbc_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ              = 50;
    localparam int OTP_PROGRAM_TIME_US  = 3000;
    localparam int PAGE_COPY_TIME_US    = 200;
    localparam int PAGE_COMPARE_TIME_US = 200;
    localparam int PAGE_REWRITE_TIME_US = 25000;
    localparam int OTP_PROGRAM_CYC      = OTP_PROGRAM_TIME_US * CLK_MHZ;
    localparam int PAGE_COPY_CYC        = PAGE_COPY_TIME_US * CLK_MHZ;
    localparam int PAGE_COMPARE_CYC     = PAGE_COMPARE_TIME_US * CLK_MHZ;
    localparam int PAGE_REWRITE_CYC     = PAGE_REWRITE_TIME_US * CLK_MHZ;
    localparam int TIMER_W              = 24;

    // ---------------------------------------------------------------
    // Opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OPC_OTP_PROG  = 8'h9b;
    localparam logic [7:0] OPC_OTP_READ  = 8'h77;
    localparam logic [7:0] OPC_XFER_B1   = 8'h53;
    localparam logic [7:0] OPC_XFER_B2   = 8'h55;
    localparam logic [7:0] OPC_COMP_B1   = 8'h60;
    localparam logic [7:0] OPC_COMP_B2   = 8'h61;
    localparam logic [7:0] OPC_REWR_B1   = 8'h58;
    localparam logic [7:0] OPC_REWR_B2   = 8'h59;

    // ---------------------------------------------------------------
    // Store layout, address fields, status bits
    // ---------------------------------------------------------------
    localparam int          OTP_BYTES    = 128;
    localparam int          USER_BYTES   = 64;
    localparam logic [1:0]  HDR_LAST     = 2'h2;
    localparam int          PAGE_W       = 12;
    localparam int          PG528_LSB    = 10;
    localparam int          PG512_LSB    = 9;
    localparam int          ST_RDY       = 7;
    localparam int          ST_COMP      = 6;
    localparam int          ST_PSIZE     = 0;
    localparam logic [7:0]  STATUS_RST   = 8'h80;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [7:0]  UNDEF_BYTE   = 8'h00;
    localparam int          FIFO_DEPTH   = 16;

    typedef enum logic [2:0] {
        F_CMD   = 3'b000,
        F_HDR   = 3'b001,
        F_DATA  = 3'b010,
        F_READ  = 3'b011,
        F_ARMED = 3'b100,
        F_SKIP  = 3'b101
    } opbc_frame_type;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PROG = 3'b001,
        OP_READ = 3'b010,
        OP_XFER = 3'b011,
        OP_COMP = 3'b100,
        OP_REWR = 3'b101
    } opbc_op_type;

    typedef enum logic [1:0] {
        E_IDLE   = 2'b00,
        E_WAIT   = 2'b01,
        E_COMMIT = 2'b10
    } opbc_eng_type;

    typedef struct packed {
        opbc_op_type         op;
        logic [PAGE_W-1:0]   page;
        logic                buf2;
    } opbc_mem_req_type;

endpackage : opbc_pkg

// file: design/opbc_top.sv
// Purpose : SPI command handling for the security store and page buffer operations
// Assumes : SPI mode 0 or 3; pins sampled directly on i_mclk
// Notes   : Main memory and SRAM buffers live outside; this block times and requests

// -------------------------------------------------------------------
// Data FIFO
// -------------------------------------------------------------------
module opbc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    // Fill side
    input  wire logic         i_push_valid,
    output logic              o_push_ready,
    input  wire logic [W-1:0] i_push_data,
    // Drain side
    output logic              o_pop_valid,
    input  wire logic         i_pop_ready,
    output logic [W-1:0]      o_pop_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("opbc_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } opbc_fifo_state_type;

    opbc_fifo_state_type st_q;
    opbc_fifo_state_type st_d;
    logic                full;
    logic                empty;

    assign empty        = (st_q.wp == st_q.rp);
    assign full         = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
    assign o_push_ready = !full;
    assign o_pop_valid  = !empty;
    assign o_pop_data   = st_q.mem[st_q.rp[AW-1:0]];

    always_comb begin
        st_d = st_q;
        if (i_push_valid && !full) begin
            st_d.mem[st_q.wp[AW-1:0]] = i_push_data;
            st_d.wp                   = st_q.wp + 1'b1;
        end
        if (i_pop_ready && !empty) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : opbc_fifo

// -------------------------------------------------------------------
// Command block
// -------------------------------------------------------------------
module opbc_top
    import opbc_pkg::*;
#(
    parameter int         P_OTP_PROG_CYC  = OTP_PROGRAM_CYC,
    parameter int         P_PAGE_COPY_CYC = PAGE_COPY_CYC,
    parameter int         P_PAGE_COMP_CYC = PAGE_COMPARE_CYC,
    parameter int         P_PAGE_REWR_CYC = PAGE_REWRITE_CYC,
    // Arbitrary value, seeds the per-device unique half
    parameter logic [7:0] P_FACTORY_SEED  = 8'h5a
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // SPI pins
    input  wire logic             i_spi_cs_n,
    input  wire logic             i_spi_sck,
    input  wire logic             i_spi_si,
    output logic                  o_spi_so,
    output logic                  o_spi_so_oe,
    // Configuration and status
    input  wire logic             i_page_512,
    output logic [7:0]            o_status,
    // Page engine outside
    output logic                  o_mem_valid,
    output opbc_mem_req_type      o_mem_req,
    input  wire logic             i_mem_mismatch,
    output logic                  o_buf1_clobber
);
    if (P_OTP_PROG_CYC < 1 || P_PAGE_COPY_CYC < 1 || P_PAGE_COMP_CYC < 1 ||
        P_PAGE_REWR_CYC < 1 || P_OTP_PROG_CYC >= (1 << TIMER_W) ||
        P_PAGE_COPY_CYC >= (1 << TIMER_W) || P_PAGE_COMP_CYC >= (1 << TIMER_W) ||
        P_PAGE_REWR_CYC >= (1 << TIMER_W)) begin : g_chk
        $error("opbc_top: cycle counts must lie between 1 and the timer range");
    end

    typedef struct packed {
        logic                          sck_q;
        logic                          cs_n_q;
        opbc_frame_type                frame;
        logic [2:0]                    bit_cnt;
        logic [6:0]                    sh;
        logic [1:0]                    hdr_cnt;
        opbc_op_type                   op;
        logic                          buf2;
        logic [23:0]                   addr;
        logic [7:0]                    rx_byte;
        logic                          rx_pend;
        logic [5:0]                    wptr;
        logic [7:0]                    rd_ptr;
        logic [7:0]                    out_sh;
        logic [2:0]                    obit;
        logic                          so;
        logic                          so_oe;
        opbc_eng_type                  eng;
        opbc_op_type                   eng_op;
        logic [TIMER_W-1:0]            timer;
        logic [5:0]                    cidx;
        logic                          locked;
        logic                          comp;
        logic [7:0]                    status;
        logic                          mem_valid;
        opbc_mem_req_type              mem_req;
        logic                          buf1_evt;
        logic [OTP_BYTES-1:0][7:0]     otp;
        logic [USER_BYTES-1:0][7:0]    stage;
    } opbc_state_type;

    opbc_state_type st_q;
    opbc_state_type st_d;
    logic           sck_rise;
    logic           sck_fall;
    logic           cs_rise;
    logic           push_ready;
    logic           pop_valid;
    logic           pop_ready;
    logic [7:0]     pop_data;
    logic [5:0]     commit_idx;
    logic [7:0]     commit_byte;

    // Reset image: user half erased, factory half from the seed
    function automatic opbc_state_type opbc_reset_image();
        opbc_state_type s;
        s = '0;
        s.frame  = F_CMD;
        s.cs_n_q = 1'b1;
        s.status = STATUS_RST;
        for (int i = 0; i < OTP_BYTES; i++) begin
            s.otp[i] = (i < USER_BYTES) ? ERASED_BYTE : 8'(P_FACTORY_SEED + 8'(i * 37));
        end
        for (int i = 0; i < USER_BYTES; i++) begin
            s.stage[i] = ERASED_BYTE;
        end
        return s;
    endfunction : opbc_reset_image

    function automatic logic [TIMER_W-1:0] opbc_load(input opbc_op_type op);
        case (op)
            OP_PROG: opbc_load = TIMER_W'(P_OTP_PROG_CYC - 1);
            OP_COMP: opbc_load = TIMER_W'(P_PAGE_COMP_CYC - 1);
            OP_REWR: opbc_load = TIMER_W'(P_PAGE_REWR_CYC - 1);
            default: opbc_load = TIMER_W'(P_PAGE_COPY_CYC - 1);
        endcase
    endfunction : opbc_load

    assign sck_rise    = i_spi_sck & ~st_q.sck_q & ~i_spi_cs_n;
    assign sck_fall    = ~i_spi_sck & st_q.sck_q & ~i_spi_cs_n;
    assign cs_rise     = i_spi_cs_n & ~st_q.cs_n_q;
    // Drain stalls while the store is being committed, so stage holds still during the copy
    assign pop_ready   = (st_q.eng != E_COMMIT);
    assign commit_idx  = st_q.cidx;
    assign commit_byte = st_q.stage[st_q.cidx];

    opbc_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_push_valid (st_q.rx_pend),
        .o_push_ready (push_ready),
        .i_push_data  (st_q.rx_byte),
        .o_pop_valid  (pop_valid),
        .i_pop_ready  (pop_ready),
        .o_pop_data   (pop_data)
    );

    always_comb begin
        logic [7:0] rx;
        rx           = {st_q.sh, i_spi_si};
        st_d         = st_q;
        st_d.sck_q   = i_spi_sck;
        st_d.cs_n_q  = i_spi_cs_n;
        st_d.mem_valid = 1'b0;
        st_d.buf1_evt  = 1'b0;
        if (st_q.rx_pend && push_ready) begin
            st_d.rx_pend = 1'b0;
        end
        // -----------------------------------------------------------
        // Frame decode
        // -----------------------------------------------------------
        if (i_spi_cs_n) begin
            st_d.bit_cnt = 3'd0;
            st_d.frame   = F_CMD;
            st_d.so_oe   = 1'b0;
        end else if (sck_rise) begin
            st_d.sh      = {st_q.sh[5:0], i_spi_si};
            st_d.bit_cnt = st_q.bit_cnt + 3'd1;
            if (st_q.bit_cnt == 3'd7) begin
                case (st_q.frame)
                    F_CMD: begin
                        st_d.hdr_cnt = 2'd0;
                        st_d.frame   = F_HDR;
                        st_d.buf2    = (rx == OPC_XFER_B2) || (rx == OPC_COMP_B2) ||
                                       (rx == OPC_REWR_B2);
                        case (rx)
                            OPC_OTP_PROG:              st_d.op = OP_PROG;
                            OPC_OTP_READ:              st_d.op = OP_READ;
                            OPC_XFER_B1, OPC_XFER_B2:  st_d.op = OP_XFER;
                            OPC_COMP_B1, OPC_COMP_B2:  st_d.op = OP_COMP;
                            OPC_REWR_B1, OPC_REWR_B2:  st_d.op = OP_REWR;
                            default:                   st_d.frame = F_SKIP;
                        endcase
                        // Commands arriving while busy are dropped whole
                        if (st_q.eng != E_IDLE) begin
                            st_d.frame = F_SKIP;
                        end
                    end
                    F_HDR: begin
                        st_d.addr    = {st_q.addr[15:0], rx};
                        st_d.hdr_cnt = st_q.hdr_cnt + 2'd1;
                        if (st_q.op == OP_PROG && rx != 8'h00) begin
                            st_d.frame = F_SKIP;
                        end else if (st_q.hdr_cnt == HDR_LAST) begin
                            case (st_q.op)
                                OP_PROG: begin
                                    st_d.frame = F_DATA;
                                    st_d.wptr  = 6'd0;
                                end
                                OP_READ: begin
                                    st_d.frame  = F_READ;
                                    st_d.out_sh = st_q.otp[0];
                                    st_d.rd_ptr = 8'd1;
                                    st_d.obit   = 3'd0;
                                end
                                default: st_d.frame = F_ARMED;
                            endcase
                        end
                    end
                    F_DATA: begin
                        st_d.rx_byte = rx;
                        st_d.rx_pend = 1'b1;
                    end
                    default: ;
                endcase
            end
        end else if (sck_fall && st_q.frame == F_READ) begin
            st_d.so_oe  = 1'b1;
            st_d.so     = st_q.out_sh[7];
            st_d.out_sh = {st_q.out_sh[6:0], 1'b0};
            st_d.obit   = st_q.obit + 3'd1;
            if (st_q.obit == 3'd7) begin
                st_d.out_sh = st_q.rd_ptr[7] ? UNDEF_BYTE : st_q.otp[st_q.rd_ptr[6:0]];
                if (!st_q.rd_ptr[7]) begin
                    st_d.rd_ptr = st_q.rd_ptr + 8'd1;
                end
            end
        end
        // -----------------------------------------------------------
        // Start of self-timed work on select rise
        // -----------------------------------------------------------
        if (cs_rise && st_q.frame == F_DATA) begin
            st_d.eng      = E_WAIT;
            st_d.eng_op   = OP_PROG;
            st_d.timer    = opbc_load(OP_PROG);
            // first buffer is the staging area
            st_d.buf1_evt = 1'b1;
        end else if (cs_rise && st_q.frame == F_ARMED) begin
            st_d.eng          = E_WAIT;
            st_d.eng_op       = st_q.op;
            st_d.timer        = opbc_load(st_q.op);
            st_d.mem_valid    = 1'b1;
            st_d.mem_req.op   = st_q.op;
            st_d.mem_req.buf2 = st_q.buf2;
            // page field depends on page size
            st_d.mem_req.page = i_page_512 ? st_q.addr[PG512_LSB +: PAGE_W]
                                           : st_q.addr[PG528_LSB +: PAGE_W];
        end
        // -----------------------------------------------------------
        // Staging drain
        // -----------------------------------------------------------
        if (pop_valid && pop_ready) begin
            st_d.stage[st_q.wptr] = pop_data;
            st_d.wptr             = st_q.wptr + 6'd1;
        end
        // -----------------------------------------------------------
        // Engine
        // -----------------------------------------------------------
        case (st_q.eng)
            E_WAIT: begin
                if (st_q.timer != '0) begin
                    st_d.timer = st_q.timer - 1'b1;
                end else if (st_q.eng_op == OP_PROG) begin
                    if (!pop_valid && !st_q.rx_pend) begin
                        st_d.eng  = E_COMMIT;
                        st_d.cidx = 6'd0;
                    end
                end else begin
                    if (st_q.eng_op == OP_COMP) begin
                        st_d.comp = i_mem_mismatch;
                    end
                    st_d.eng = E_IDLE;
                end
            end
            E_COMMIT: begin
                if (!st_q.locked) begin
                    st_d.otp[st_q.cidx] = st_q.stage[st_q.cidx];
                end
                st_d.cidx = st_q.cidx + 6'd1;
                if (st_q.cidx == 6'(USER_BYTES - 1)) begin
                    st_d.locked = 1'b1;
                    st_d.eng    = E_IDLE;
                end
            end
            default: ;
        endcase
        st_d.status           = 8'h00;
        st_d.status[ST_RDY]   = (st_d.eng == E_IDLE);
        st_d.status[ST_COMP]  = st_d.comp;
        st_d.status[ST_PSIZE] = i_page_512;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= opbc_reset_image();
        end else begin
            st_q <= st_d;
        end
    end

    assign o_spi_so       = st_q.so;
    assign o_spi_so_oe    = st_q.so_oe;
    assign o_status       = st_q.status;
    assign o_mem_valid    = st_q.mem_valid;
    assign o_mem_req      = st_q.mem_req;
    assign o_buf1_clobber = st_q.buf1_evt;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_prog_busy_start: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cs_rise && st_q.frame == F_DATA) |=> (!o_status[ST_RDY] && o_buf1_clobber))
        else $error("program did not go busy on select rise");
    a_page_busy_req: assert property (@(posedge i_mclk) disable iff (i_rst)
        (cs_rise && st_q.frame == F_ARMED) |=> (!o_status[ST_RDY] && o_mem_valid) [*1] ##1 !o_mem_valid)
        else $error("page operation not requested or not busy");
    a_ready_tracks: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_status[ST_RDY] == (st_q.eng == E_IDLE))
        else $error("ready bit disagrees with engine");
    a_comp_result: assert property (@(posedge i_mclk) disable iff (i_rst)
        (st_q.eng == E_WAIT && st_q.eng_op == OP_COMP && st_q.timer == '0)
        |=> (o_status[ST_COMP] == $past(i_mem_mismatch) && o_status[ST_RDY]))
        else $error("compare result not posted");
    a_factory_fixed: assert property (@(posedge i_mclk) disable iff (i_rst)
        1'b1 |=> st_q.otp[OTP_BYTES-1:USER_BYTES] == $past(st_q.otp[OTP_BYTES-1:USER_BYTES]))
        else $error("factory half changed");
    a_user_locked: assert property (@(posedge i_mclk) disable iff (i_rst)
        st_q.locked |=> st_q.otp[USER_BYTES-1:0] == $past(st_q.otp[USER_BYTES-1:0]))
        else $error("user half changed after lock");
    a_wrap_ptr: assert property (@(posedge i_mclk) disable iff (i_rst)
        (pop_valid && pop_ready && st_q.wptr == 6'd63) |=> st_q.wptr == 6'd0)
        else $error("staging pointer did not wrap");
    a_commit_write: assert property (@(posedge i_mclk) disable iff (i_rst)
        (st_q.eng == E_COMMIT && !st_q.locked)
        |=> st_q.otp[$past(commit_idx)] == $past(commit_byte))
        else $error("staged byte not written to store");
    a_so_release: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_spi_cs_n |=> !o_spi_so_oe)
        else $error("serial output driven with select high");
    a_page_size_bit: assert property (@(posedge i_mclk) disable iff (i_rst)
        ##1 o_status[ST_PSIZE] == $past(i_page_512))
        else $error("page size bit stale");

endmodule : opbc_top

// file: test/opbc_host.sv
// Purpose : SPI host model that sends command frames to the block
// Assumes : Mode 0, clock idles low, each clock phase lasts 3 mclk
// Notes   : Serial in is flipped while deselected, so stale bits never look valid
module opbc_host (
    // Clock
    input  wire logic i_mclk,
    // SPI pins
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_cs_n = 1'b0;
            o_si = tx[i];
            repeat (3) @(posedge i_mclk);
            #1 rx[i] = i_so;
            o_sck = 1'b1;
            repeat (3) @(posedge i_mclk);
            #1 o_sck = 1'b0;
        end
    endtask : xb
    task automatic stop();
        repeat (3) @(posedge i_mclk);
        #1 o_cs_n = 1'b1;
        o_si = ~o_si;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask : stop
endmodule : opbc_host

// file: test/opbc_top_test.sv
// Purpose : Self-checking bench for the command block and its FIFO
// Assumes : Short timer parameters keep the run small
// Notes   : Random values come from an xorshift seeded with a fixed value
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module opbc_top_test;
    import opbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 12, PR = 16, PP = 20;
    localparam logic [7:0] SEED = 8'h3c;
    logic i_mclk, i_rst, i_spi_cs_n, i_spi_sck, i_spi_si, o_spi_so, o_spi_so_oe;
    logic i_page_512, i_mem_mismatch, o_mem_valid, o_buf1_clobber;
    logic [7:0] o_status, fd, r, ex[128];
    opbc_mem_req_type o_mem_req, got;
    int failures, n_checks, cyc, nval, nclob, k, n;
    logic [31:0] rs;
    logic [7:0] opcs[6] = '{OPC_XFER_B1, OPC_XFER_B2, OPC_COMP_B1, OPC_COMP_B2,
                            OPC_REWR_B1, OPC_REWR_B2};
    opbc_top #(.P_OTP_PROG_CYC(PP), .P_PAGE_COPY_CYC(PC), .P_PAGE_COMP_CYC(PC),
        .P_PAGE_REWR_CYC(PR), .P_FACTORY_SEED(SEED)) dut (.i_mclk, .i_rst,
        .i_spi_cs_n, .i_spi_sck, .i_spi_si, .o_spi_so, .o_spi_so_oe, .i_page_512,
        .o_status, .o_mem_valid, .o_mem_req, .i_mem_mismatch, .o_buf1_clobber);
    // A released output shows the inverse, so a late enable cannot pass unseen
    opbc_host host (.i_mclk, .o_cs_n(i_spi_cs_n), .o_sck(i_spi_sck),
        .o_si(i_spi_si), .i_so(o_spi_so_oe ? o_spi_so : !o_spi_so));
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic wrdy(input int lim);
        k = 0;
        `CHK(o_status[ST_RDY], 1'b0)
        while (o_status[ST_RDY] !== 1'b1 && k < 3000) begin
            @(posedge i_mclk);
            #1 k++;
        end
        `CHK(k >= lim && k < 3000, 1'b1)
    endtask : wrdy
    task automatic rd_all();
        host.xb(OPC_OTP_READ, r);
        repeat (3) host.xb(8'(xs()), r);
        for (int i = 0; i < 129; i++) begin
            host.xb(8'(xs()), r);
            `CHK(r, (i < 128) ? ex[i] : UNDEF_BYTE)
        end
        `CHK(o_spi_so_oe, 1'b1)
        host.stop();
        `CHK(o_spi_so_oe, 1'b0)
    endtask : rd_all
    task automatic prog(input int cnt, input logic upd);
        n = nclob;
        host.xb(OPC_OTP_PROG, r);
        repeat (3) host.xb(8'h00, r);
        for (int i = 0; i < cnt; i++) begin
            fd = 8'(xs());
            host.xb(fd, r);
            if (upd) ex[i % 64] = fd;
        end
        host.stop();
        `CHK(dut.st_q.wptr, 6'(cnt % 64))
        wrdy(PP);
        `CHK(nclob, n + 1)
        `CHK({dut.pop_valid, dut.push_ready, dut.st_q.rx_pend}, 3'b010)
        `CHK(dut.st_q.locked, 1'b1)
    endtask : prog
    always @(posedge i_mclk) begin
        cyc++;
        if (o_mem_valid === 1'b1) nval++;
        if (o_mem_valid === 1'b1) got = o_mem_req;
        if (o_buf1_clobber === 1'b1) nclob++;
        if (cyc > 40000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial begin : main
        logic [11:0] pg;
        logic [23:0] a;
        int j6;
        {i_rst, i_page_512, i_mem_mismatch, fd, rs} = {3'b100, 8'h00, 32'hafb5};
        repeat (3) @(posedge i_mclk);
        #1 `CHK(o_status, STATUS_RST)
        i_rst = 1'b0;
        for (int i = 0; i < 128; i++) ex[i] = (i < 64) ? ERASED_BYTE : SEED + 8'(i * 37);
        // ----------------------------------------------------------
        // Page commands, every opcode in both layouts
        // ----------------------------------------------------------
        for (int j = 0; j < 12; j++) begin
            j6 = j % 6;
            pg = 12'(xs());
            a = 24'(xs());
            i_page_512 = (j >= 6);
            i_mem_mismatch = rs[7];
            if (i_page_512) a[20:9] = pg;
            else a[21:10] = pg;
            n = nval;
            host.xb(opcs[j6], r);
            for (int b = 2; b >= 0; b--) host.xb(a[b*8+:8], r);
            host.stop();
            wrdy((j6 < 4) ? PC - 2 : PR - 2);
            `CHK(nval, n + 1)
            `CHK(got, {(j6 < 2) ? OP_XFER : (j6 < 4) ? OP_COMP : OP_REWR, pg, j6[0]})
            `CHK(o_status[ST_PSIZE], i_page_512)
            if (j6 == 2 || j6 == 3) `CHK(o_status[ST_COMP], i_mem_mismatch)
        end
        // ----------------------------------------------------------
        // Security store: read, program with wrap, locked reprogram
        // ----------------------------------------------------------
        rd_all();
        prog(65, 1'b1);
        rd_all();
        prog(10, 1'b0);
        rd_all();
        stop_test();
    end
endmodule : opbc_top_test
